// ### shared/nmp_params.svh
// Constants for the multi-plane program and ID readout host controller.
`ifndef NMP_PARAMS_SVH
`define NMP_PARAMS_SVH
`define NMP_CMD_LOAD       8'h80
`define NMP_CMD_LOAD2      8'h81
`define NMP_CMD_DUMMY      8'h11
`define NMP_CMD_CONFIRM    8'h10
`define NMP_CMD_CACHE      8'h15
`define NMP_CMD_STATUS     8'h70
`define NMP_CMD_RESET      8'hff
`define NMP_CMD_READID     8'h90
`define NMP_ID_ADDR_LEGACY 8'h00
`define NMP_ID_ADDR_SIG    8'h40
`define NMP_ID_LEN_LEGACY  3'd6
`define NMP_ID_LEN_SIG     3'd6
`define NMP_STAT_RDY_BIT   6
`define NMP_PULSE_NS       40
`define NMP_PULSE_CYC      ((`NMP_PULSE_NS + 19) / 20)
`define NMP_ADDR_CYCLES    3'd5
`define NMP_WB_CYC         3'd7
`endif

// ### shared/nmp_pkg.sv
// Types shared by the host controller files.
package nmp_pkg;
	// Kind of bus cycle handed to the pin driver.
	typedef enum logic [1:0] {
		NMP_CY_CMD,
		NMP_CY_ADDR,
		NMP_CY_WDATA,
		NMP_CY_RDATA
	} nmp_cycle_type;

	// One bus cycle request.
	typedef struct packed {
		nmp_cycle_type kind;
		logic [7:0]    data;
	} nmp_req_type;

	// Operations the user can order.
	typedef enum logic [2:0] {
		NMP_OP_PROG2,
		NMP_OP_CACHE2,
		NMP_OP_CACHE_END,
		NMP_OP_READ_ID,
		NMP_OP_RECOVER
	} nmp_op_type;
endpackage : nmp_pkg

// ### src/nmp_cycle.sv
// Drives one command, address or data cycle on the flash pins.
`timescale 1ns/1ps
`default_nettype none
`include "nmp_params.svh"
module nmp_cycle (
	// Clock and reset.
	input  wire logic            clk,
	input  wire logic            sys_rst,
	// Request side.
	input  wire logic            req_valid,
	input  var  nmp_pkg::nmp_req_type req,
	output logic                 req_ready,
	output logic                 done,
	output logic [7:0]           rdata,
	// Flash pins.
	output logic                 cle,
	output logic                 ale,
	output logic                 we_n,
	output logic                 re_n,
	input  wire logic [7:0]      io_in,
	output logic [7:0]           io_out,
	output logic                 io_oe
);
	import nmp_pkg::*;
	localparam logic [3:0] PCYC = 4'(`NMP_PULSE_CYC);
	typedef enum logic [1:0] {NMP_CI, NMP_CLOW, NMP_CHIGH} nmp_cst_type;
	nmp_cst_type   st, next_st;
	logic [3:0]    cnt, next_cnt;
	nmp_req_type   cur, next_cur;
	logic [7:0]    next_rdata;

	// Strobe low for the pulse time, then high for the same time.
	always_comb begin
		next_st = st;
		next_cnt = cnt;
		next_cur = cur;
		next_rdata = rdata;
		done = 1'b0;
		case (st)
			NMP_CI: if (req_valid) begin
				next_cur = req;
				next_cnt = PCYC;
				next_st = NMP_CLOW;
			end
			NMP_CLOW: if (cnt == 4'h1) begin
				if (cur.kind == NMP_CY_RDATA)
					next_rdata = io_in; // Data is stable near the end of low phase.
				next_cnt = PCYC;
				next_st = NMP_CHIGH;
			end else begin
				next_cnt = cnt - 4'h1;
			end
			NMP_CHIGH: if (cnt == 4'h1) begin
				done = 1'b1;
				next_st = NMP_CI;
			end else begin
				next_cnt = cnt - 4'h1;
			end
			default: next_st = NMP_CI;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= NMP_CI;
			cnt <= 4'h0;
			cur <= '0;
			rdata <= 8'h00;
		end else begin
			st <= next_st;
			cnt <= next_cnt;
			cur <= next_cur;
			rdata <= next_rdata;
		end
	end

	// Pin levels follow the current cycle kind.
	assign req_ready = (st == NMP_CI);
	assign cle = (st != NMP_CI) && (cur.kind == NMP_CY_CMD);
	assign ale = (st != NMP_CI) && (cur.kind == NMP_CY_ADDR);
	assign we_n = !((st == NMP_CLOW) && (cur.kind != NMP_CY_RDATA));
	assign re_n = !((st == NMP_CLOW) && (cur.kind == NMP_CY_RDATA));
	assign io_oe = (st != NMP_CI) && (cur.kind != NMP_CY_RDATA);
	assign io_out = cur.data;
endmodule : nmp_cycle
`default_nettype wire

// ### src/nmp_host.sv
// Host controller: two-plane program, cache program end and ID readout.
`timescale 1ns/1ps
`default_nettype none
`include "nmp_params.svh"
// Contract
// - Between 11h and 81h only status or reset.
// - End cache program with load then 10h.
// - After 15h end, poll status until ready.
// - Then issue reset before next operation.
module nmp_host (
	// Clock and reset.
	input  wire logic            clk,
	input  wire logic            sys_rst,
	// User orders.
	input  wire logic            op_valid,
	input  var  nmp_pkg::nmp_op_type op,
	input  wire logic [7:0]      op_arg,
	output logic                 op_ready,
	input  wire logic [7:0]      wr_data,
	input  wire logic            wr_valid,
	output logic                 wr_ready,
	output logic [7:0]           rd_data,
	output logic                 rd_valid,
	output logic                 op_done,
	output logic                 op_fail,
	// Flash pins.
	output logic                 cle,
	output logic                 ale,
	output logic                 we_n,
	output logic                 re_n,
	output logic                 ce_n,
	input  wire logic            rb_n,
	input  wire logic [7:0]      io_in,
	output logic [7:0]           io_out,
	output logic                 io_oe
);
	import nmp_pkg::*;
	typedef enum logic [3:0] {
		NMP_IDLE, NMP_CMD0, NMP_ADDR, NMP_DATA, NMP_CMD1,
		NMP_WAITRB, NMP_POLLC, NMP_POLLR, NMP_RESETC, NMP_IDRD,
		NMP_FIN
	} nmp_st_type;

	nmp_st_type  st, next_st;
	nmp_op_type  cop, next_cop;
	logic [7:0]  arg, next_arg;
	logic [2:0]  cnt, next_cnt;
	logic        plane, next_plane;
	logic        rb_s1, rb_s2, rb_s3, rb_ok;
	logic        cy_valid, cy_ready, cy_done;
	nmp_req_type cy_req;
	logic [7:0]  cy_rdata;
	logic        next_rd_valid, next_op_done, next_op_fail;
	logic [7:0]  next_rd_data;

	// Three-stage sampling of ready/busy; a change counts when the last two stages agree.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rb_s1 <= 1'b0;
			rb_s2 <= 1'b0;
			rb_s3 <= 1'b0;
			rb_ok <= 1'b0;
		end else begin
			rb_s1 <= rb_n;
			rb_s2 <= rb_s1;
			rb_s3 <= rb_s2;
			if (rb_s2 == rb_s3)
				rb_ok <= rb_s3;
		end
	end

	nmp_cycle nmp_cycle_i (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.req_valid (cy_valid),
		.req       (cy_req),
		.req_ready (cy_ready),
		.done      (cy_done),
		.rdata     (cy_rdata),
		.cle       (cle),
		.ale       (ale),
		.we_n      (we_n),
		.re_n      (re_n),
		.io_in     (io_in),
		.io_out    (io_out),
		.io_oe     (io_oe)
	);

	// Sequencer: one bus cycle in flight, stepped on its done pulse.
	always_comb begin
		next_st = st;
		next_cop = cop;
		next_arg = arg;
		next_cnt = cnt;
		next_plane = plane;
		next_rd_valid = 1'b0;
		next_rd_data = rd_data;
		next_op_done = 1'b0;
		next_op_fail = op_fail;
		cy_valid = 1'b0;
		cy_req = '{kind: NMP_CY_CMD, data: 8'h00};
		wr_ready = 1'b0;
		case (st)
			NMP_IDLE: if (op_valid) begin
				next_cop = op;
				next_arg = op_arg;
				next_plane = 1'b0;
				next_op_fail = 1'b0;
				next_st = (op == NMP_OP_RECOVER) ? NMP_POLLC : NMP_CMD0;
			end
			NMP_CMD0: begin
				cy_valid = 1'b1;
				if (cop == NMP_OP_READ_ID)
					cy_req.data = `NMP_CMD_READID;
				else if (plane)
					cy_req.data = `NMP_CMD_LOAD2;
				else
					cy_req.data = `NMP_CMD_LOAD;
				if (cy_done) begin
					next_cnt = (cop == NMP_OP_READ_ID) ? 3'd1
						: `NMP_ADDR_CYCLES;
					next_st = NMP_ADDR;
				end
			end
			NMP_ADDR: begin
				cy_valid = 1'b1;
				cy_req.kind = NMP_CY_ADDR;
				// Only the ID address is selectable by the user.
				cy_req.data = (cop == NMP_OP_READ_ID) ? arg : 8'h00;
				if (cy_done) begin
					next_cnt = cnt - 3'd1;
					if (cnt == 3'd1) begin
						next_cnt = (arg == `NMP_ID_ADDR_SIG) ?
							`NMP_ID_LEN_SIG : `NMP_ID_LEN_LEGACY;
						next_st = (cop == NMP_OP_READ_ID) ?
							NMP_IDRD : NMP_DATA;
					end
				end
			end
			NMP_DATA: begin
				// User data streams until it stops offering bytes.
				cy_valid = wr_valid;
				wr_ready = cy_ready;
				cy_req.kind = NMP_CY_WDATA;
				cy_req.data = wr_data;
				if (!wr_valid && cy_ready)
					next_st = NMP_CMD1;
			end
			NMP_CMD1: begin
				cy_valid = 1'b1;
				if (!plane)
					cy_req.data = `NMP_CMD_DUMMY;
				else if (cop == NMP_OP_CACHE2)
					cy_req.data = `NMP_CMD_CACHE;
				else
					cy_req.data = `NMP_CMD_CONFIRM;
				if (cy_done) begin
					next_cnt = `NMP_WB_CYC;
					next_st = NMP_WAITRB;
				end
			end
			NMP_WAITRB: begin
				// Busy may last both pages' program time here.
				// The hold-off lets the busy level pass the sampling stages,
				// so a stale ready is never taken for the end of the work.
				if (cnt != 3'd0) begin
					next_cnt = cnt - 3'd1;
				end else if (rb_ok) begin
					if (!plane) begin
						next_plane = 1'b1; // Only 81h may follow.
						next_st = NMP_CMD0;
					end else begin
						next_st = NMP_FIN;
					end
				end
			end
			NMP_POLLC: begin
				cy_valid = 1'b1;
				cy_req.data = `NMP_CMD_STATUS;
				if (cy_done)
					next_st = NMP_POLLR;
			end
			NMP_POLLR: begin
				cy_valid = 1'b1;
				cy_req.kind = NMP_CY_RDATA;
				if (cy_done)
					next_st = cy_rdata[`NMP_STAT_RDY_BIT] ?
						NMP_RESETC : NMP_POLLC;
			end
			NMP_RESETC: begin
				cy_valid = 1'b1;
				cy_req.data = `NMP_CMD_RESET;
				if (cy_done)
					next_st = NMP_FIN;
			end
			NMP_IDRD: begin
				cy_valid = 1'b1;
				cy_req.kind = NMP_CY_RDATA;
				if (cy_done) begin
					next_rd_data = cy_rdata;
					next_rd_valid = 1'b1;
					next_cnt = cnt - 3'd1;
					if (cnt == 3'd1)
						next_st = NMP_FIN;
				end
			end
			NMP_FIN: begin
				next_op_done = 1'b1;
				next_st = NMP_IDLE;
			end
			default: next_st = NMP_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= NMP_IDLE;
			cop <= NMP_OP_PROG2;
			arg <= 8'h00;
			cnt <= 3'd0;
			plane <= 1'b0;
			rd_valid <= 1'b0;
			rd_data <= 8'h00;
			op_done <= 1'b0;
			op_fail <= 1'b0;
		end else begin
			st <= next_st;
			cop <= next_cop;
			arg <= next_arg;
			cnt <= next_cnt;
			plane <= next_plane;
			rd_valid <= next_rd_valid;
			rd_data <= next_rd_data;
			op_done <= next_op_done;
			op_fail <= next_op_fail;
		end
	end

	assign op_ready = (st == NMP_IDLE);
	assign ce_n = (st == NMP_IDLE);

	// Second plane load must directly follow the first-plane wait.
	a_plane_order: assert property (@(posedge clk) disable iff (sys_rst)
		(st == NMP_WAITRB && !plane && rb_ok && cnt == 3'd0) |=>
		(st == NMP_CMD0 && plane))
		else $error("second plane load not next");
	// No command follows the ready/busy wait while the device reports busy.
	a_busy_hold: assert property (@(posedge clk) disable iff (sys_rst)
		(st == NMP_WAITRB && !rb_ok) |=> (st == NMP_WAITRB))
		else $error("busy wait left early");
	// Status poll ends in a reset cycle once ready.
	a_reset_after: assert property (@(posedge clk) disable iff (sys_rst)
		(st == NMP_POLLR && cy_done && cy_rdata[6]) |=>
		(st == NMP_RESETC))
		else $error("reset not issued after ready");
	// Poll repeats while busy.
	a_poll_repeat: assert property (@(posedge clk) disable iff (sys_rst)
		(st == NMP_POLLR && cy_done && !cy_rdata[6]) |=>
		(st == NMP_POLLC))
		else $error("status poll not repeated");
	// Each ID read cycle yields one byte.
	a_id_byte: assert property (@(posedge clk) disable iff (sys_rst)
		(st == NMP_IDRD && cy_done) |=> rd_valid)
		else $error("ID byte not delivered");
endmodule : nmp_host
`default_nettype wire

// ### testbench/nmp_flash_model.sv
// Behavioural flash device that answers the host controller pins.
`timescale 1ns/1ps
`default_nettype none
module nmp_flash_model #(
	parameter logic [47:0] LEGACY  = 48'h0,
	parameter logic [47:0] SIG     = 48'h0,
	parameter int          LONG_NS = 20000
) (
	// Host strobes and bus.
	input  wire logic       cle,
	input  wire logic       ale,
	input  wire logic       we_n,
	input  wire logic       re_n,
	input  wire logic       ce_n,
	input  wire logic [7:0] io_out,
	// Device answers.
	output logic            rb_n,
	output logic [7:0]      io_in
);
	logic [7:0] cmd, addr;
	logic       array_busy, early_reset;
	int         idx, polls;
	logic [7:0] data_q[$];

	// Idle and ready at power up.
	initial begin
		{rb_n, io_in, cmd, addr} = {1'h1, 24'h0};
		{array_busy, early_reset, idx, polls} = '0;
	end

	// A closing program first waits out the cached page still in work.
	task automatic start_busy(input logic [7:0] c);
		rb_n = 1'h0;
		if (c != 8'h11) wait (!array_busy);
		if (c == 8'h15) begin
			array_busy = 1'h1;
			#400 rb_n = 1'h1;
			#(LONG_NS) array_busy = 1'h0;
		end else begin
			#(c == 8'h11 ? 400 : LONG_NS) rb_n = 1'h1;
		end
	endtask : start_busy

	// Command, address and data are latched on the write strobe rising.
	always @(posedge we_n) if (!ce_n) begin
		if (cle) begin
			cmd = io_out;
			idx = 0;
			if (cmd == 8'hff) early_reset |= array_busy;
			if (cmd inside {8'h10, 8'h11, 8'h15}) fork
				start_busy(cmd);
			join_none
		end else if (ale) addr = io_out;
		else data_q.push_back(io_out);
	end

	// Status bit 6 stays low until the array itself is free.
	always @(negedge re_n) if (!ce_n) begin
		if (cmd == 8'h70) begin
			io_in = {1'h0, rb_n & ~array_busy, 6'h00};
			polls += int'(array_busy);
		end else begin
			io_in = (addr == 8'h40) ? SIG[47 - 8 * idx -: 8]
				: LEGACY[47 - 8 * idx -: 8];
			idx++;
		end
	end

	// Past the hold time the bus no longer keeps the old byte.
	always @(posedge re_n) #5 io_in = ~io_in;
endmodule : nmp_flash_model
`default_nettype wire

// ### testbench/nmp_host_tb_top.sv
// Self-checking testbench for the flash host controller.
`timescale 1ns/1ps
`default_nettype none
module nmp_host_tb_top;
	import nmp_pkg::*;
	// Cache, no interleave, one page, four levels, one die.
	localparam logic [7:0] ID3 = {1'h1, 1'h0, 2'h0, 2'h1, 2'h0};
	// 1MB block, 640B spare, 8KB page.
	localparam logic [7:0] ID4 = {1'h0, 1'h1, 2'h3, 1'h1, 1'h0, 2'h2};
	// 24bit correction, two planes, reserved bits zero.
	localparam logic [7:0] ID5 = {1'h0, 3'h5, 3'h2, 1'h0};
	// Toggle, extended_data_out, 2xnm.
	localparam logic [7:0] ID6 = {1'h1, 1'h1, 3'h0, 3'h3};
	// Maker, device and signature codes are arbitrary.
	localparam logic [47:0] LEGACY = {8'h5a, 8'ha7, ID3, ID4, ID5, ID6};
	localparam logic [47:0] SIG    = {"SGNTR", 5'h00, 3'h2};

	logic       clk, sys_rst, op_valid, wr_valid, op_ready, wr_ready;
	logic       rd_valid, op_done, op_fail, cle, ale, we_n, re_n, ce_n;
	logic       rb_n, io_oe, take, want, id_on;
	logic [7:0] op_arg, wr_data, rd_data, io_in, io_out;
	nmp_op_type op;
	int         mismatches, tests_run, fed;
	logic [7:0] exp_q[$], cmd_q[$], sent_q[$];

	nmp_host nmp_host_i (.clk(clk), .sys_rst(sys_rst), .op_valid(op_valid),
		.op(op), .op_arg(op_arg), .op_ready(op_ready), .wr_data(wr_data),
		.wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data),
		.rd_valid(rd_valid), .op_done(op_done), .op_fail(op_fail),
		.cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n), .ce_n(ce_n),
		.rb_n(rb_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe));
	nmp_flash_model #(.LEGACY(LEGACY), .SIG(SIG)) nmp_flash_model_i (
		.cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n), .ce_n(ce_n),
		.io_out(io_out), .rb_n(rb_n), .io_in(io_in));

	// Free running 50 MHz clock.
	always #10 clk = ~clk;

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic test_done;
		$display("mismatches %0d, tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : test_done

	// One order while idle; completion is awaited under a bound.
	task automatic run_op(input nmp_op_type o, input logic [7:0] a);
		int n;
		n = 0;
		cmd_q.delete();
		sent_q.delete();
		nmp_flash_model_i.data_q.delete();
		@(posedge clk);
		op <= o;
		op_arg <= a;
		op_valid <= 1'h1;
		@(posedge clk);
		op_valid <= 1'h0;
		do @(negedge clk); while (op_done !== 1'h1 && n++ < 20000);
		if (n >= 20000) begin
			mismatches++;
			$display("[ERR] %0t: order never completed", $time);
			test_done();
		end
		check(8'({op_ready, op_fail, io_oe}), 8'h04);
	endtask : run_op

	task automatic expect_cmds(input logic [31:0] seq, input int len);
		check(8'(cmd_q.size()), 8'(len));
		for (int i = 0; i < len; i++)
			check(cmd_q[i], seq[31 - 8 * i -: 8]);
	endtask : expect_cmds

	// The six replies are noted before the order goes out.
	task automatic read_id(input logic [7:0] a, input logic [47:0] tbl);
		for (int i = 0; i < 6; i++) exp_q.push_back(tbl[47 - 8 * i -: 8]);
		run_op(NMP_OP_READ_ID, a);
		check(nmp_flash_model_i.addr, a);
		check(8'(exp_q.size()), 8'h00);
	endtask : read_id

	// Handshake is sampled mid-cycle, so the taking edge is known.
	always @(negedge clk) take = wr_valid & wr_ready;
	// Four bytes per plane load, fresh random data after each.
	always @(posedge clk) begin
		if (take) begin
			sent_q.push_back(wr_data);
			wr_data <= 8'($urandom);
			fed++;
			if (fed == 4) wr_valid <= 1'h0;
		end
		if (want) begin
			want = 1'h0;
			fed = 0;
			wr_valid <= 1'h1;
		end
	end

	// Commands latched on the pins; a load command opens a data phase.
	always @(posedge we_n) if (cle === 1'h1) begin
		cmd_q.push_back(io_out);
		if (io_out inside {8'h80, 8'h81}) want = 1'h1;
	end

	// ID bytes on the user side are matched to the oldest note.
	always @(negedge clk) if (id_on && rd_valid === 1'h1) begin
		if (exp_q.size() > 0) check(rd_data, exp_q.pop_front());
		else check(rd_data, ~rd_data);
	end

	initial begin
		{clk, sys_rst, op_valid, wr_valid, take, want, id_on} = 7'h20;
		{op_arg, wr_data, mismatches, tests_run, fed} = '0;
		op = NMP_OP_PROG2;
		void'($urandom(32'h6868e560));
		wr_data = 8'($urandom);
		repeat (4) @(posedge clk);
		sys_rst <= 1'h0;
		run_op(NMP_OP_PROG2, 8'h00);
		expect_cmds(32'h8011_8110, 4);
		check(8'(nmp_flash_model_i.data_q.size()), 8'h08);
		foreach (sent_q[i])
			check(nmp_flash_model_i.data_q[i], sent_q[i]);
		run_op(NMP_OP_CACHE2, 8'h00);
		expect_cmds(32'h8011_8115, 4);
		run_op(NMP_OP_CACHE_END, 8'h00);
		expect_cmds(32'h8011_8110, 4);
		check(8'(nmp_flash_model_i.array_busy), 8'h00);
		run_op(NMP_OP_CACHE2, 8'h00);
		run_op(NMP_OP_RECOVER, 8'h00);
		// One status command per busy answer, one more, then the reset.
		check(8'(cmd_q.size()), 8'(nmp_flash_model_i.polls + 2));
		check(cmd_q[0], 8'h70);
		check(cmd_q[cmd_q.size() - 1], 8'hff);
		check(8'(nmp_flash_model_i.polls > 1), 8'h01);
		check(8'(nmp_flash_model_i.early_reset), 8'h00);
		id_on = 1'h1;
		read_id(8'h00, LEGACY);
		read_id(8'h40, SIG);
		test_done();
	end

	// The run needs under a hundred microseconds; far beyond is a hang.
	initial begin
		#1_000_000;
		mismatches++;
		test_done();
	end
endmodule : nmp_host_tb_top
`default_nettype wire
